// *** design/twm_top.v ***
// Purpose: Register map, pin routing and event logic of the two-wire master.
// Assumes: Classic Wishbone slave, one-cycle ack, 10 MHz clock.
// Notes:   Data buffer memory is modelled as byte ports to the outside.
// How it works
// - Clock and data routed to selected pins
// - Routing applies only while master enabled
// - Disabled master hands pins back to GPIO
// - Writing bit 0 triggers a task
// - Suspended event once traffic halts
// - Last-receive event at final byte start
// - Last-transmit event at final byte start
// - Distinct receive and transmit start events
// - Count registers hold bytes moved
// - Transfers limited by maximum-count registers
// - Shortcuts link events to tasks
// - Target address sent each transfer
// - Stopped event after stop completes
// - Suspend ignored when idle, byte finishes
`default_nettype none
`include "twm_consts.vh"

module twm_top (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [11:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output wire        irq_o,
   input  wire [7:0]  pin_in_i,
   input  wire [7:0]  gpio_out_i,
   input  wire [7:0]  gpio_oe_i,
   output reg  [7:0]  pin_out_o,
   output reg  [7:0]  pin_oe_o,
   input  wire [7:0]  tx_byte_i,
   output wire [7:0]  rx_byte_o,
   output wire        rx_byte_valid_o,
   output wire [31:0] rx_addr_o,
   output wire [31:0] tx_addr_o
);
   reg  [31:0] mask_q, links_q, route_clk_q, route_dat_q, rate_q;
   reg  [31:0] rx_ptr_q, tx_ptr_q, rx_lim_q, tx_lim_q, rx_list_q, tx_list_q;
   reg  [31:0] rx_moved_q, tx_moved_q, target_q;
   reg  [3:0]  on_q;
   reg  [2:0]  cause_q;
   reg  [6:0]  ev_q;
   reg  [2:0]  scl_s_q, sda_s_q;
   reg         scl_f_q, sda_f_q, tx_side;
   reg  [31:0] rd_d;
   wire        sel_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   wire        sel_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   wire        enabled = (on_q == `TWM_ON_VALUE);
   wire        e_halt, e_fault, e_paused, e_rxb, e_txb, e_frx, e_ftx, e_byte, busy, paused;
   wire [7:0]  count;
   wire        scl_low, sda_low;

   function hit;
      input [11:0] ofs;
      hit = (wb_adr_i == ofs);
   endfunction

   function task_wr;
      input [11:0] ofs;
      task_wr = sel_wr && hit(ofs) && wb_dat_i[0];
   endfunction

   function [2:0] route_pin;
      input [31:0] r;
      route_pin = r[2:0];
   endfunction

   function routed;
      input [31:0] r;
      routed = !r[`TWM_ROUTE_OFF_BIT];
   endfunction

   // Tasks from register writes, with shortcuts from the engine's event pulses
   wire go_rx = enabled && (task_wr(`TWM_OFS_RX_GO)
                || (e_ftx && links_q[`TWM_LK_FTX_RX]));
   wire go_tx = enabled && (task_wr(`TWM_OFS_TX_GO)
                || (e_frx && links_q[`TWM_LK_FRX_TX]));
   wire halt  = task_wr(`TWM_OFS_HALT) || (e_ftx && links_q[`TWM_LK_FTX_HALT])
                || (e_frx && links_q[`TWM_LK_FRX_HALT]);
   wire pause = task_wr(`TWM_OFS_PAUSE) || (e_ftx && links_q[`TWM_LK_FTX_PAUSE]);
   wire cont  = task_wr(`TWM_OFS_CONT);

   // Pin sampling: a change counts once stages two and three agree
   always @(posedge clk_i) begin
      if (rst_i) begin
         scl_s_q <= 3'h7; sda_s_q <= 3'h7; scl_f_q <= 1'b1; sda_f_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], pin_in_i[route_pin(route_clk_q)]};
         sda_s_q <= {sda_s_q[1:0], pin_in_i[route_pin(route_dat_q)]};
         if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
      end
   end

   twm_bus_engine u_eng (
      .clk_i         (clk_i),
      .rst_i         (rst_i || !enabled),
      .go_rx_i       (go_rx),
      .go_tx_i       (go_tx),
      .halt_i        (halt),
      .pause_i       (pause),
      .cont_i        (cont),
      .target_i      (target_q[6:0]),
      .rx_limit_i    (rx_lim_q[7:0]),
      .tx_limit_i    (tx_lim_q[7:0]),
      .tx_byte_i     (tx_byte_i),
      .scl_in_i      (scl_f_q),
      .sda_in_i      (sda_f_q),
      .scl_low_o     (scl_low),
      .sda_low_o     (sda_low),
      .ev_halted_o   (e_halt),
      .ev_fault_o    (e_fault),
      .ev_paused_o   (e_paused),
      .ev_rx_begun_o (e_rxb),
      .ev_tx_begun_o (e_txb),
      .ev_fin_rx_o   (e_frx),
      .ev_fin_tx_o   (e_ftx),
      .byte_done_o   (e_byte),
      .rx_byte_o     (rx_byte_o),
      .count_o       (count),
      .busy_o        (busy),
      .paused_o      (paused)
   );

   assign rx_byte_valid_o = e_byte && busy && !tx_side;
   assign rx_addr_o = rx_ptr_q + {24'h000000, count};
   assign tx_addr_o = tx_ptr_q + {24'h000000, count};

   // Pin mux: routing only while enabled, else GPIO owns every pin
   integer i;
   always @(posedge clk_i) begin
      if (rst_i) begin
         pin_out_o <= 8'h00; pin_oe_o <= 8'h00;
      end else begin
         for (i = 0; i < 8; i = i + 1) begin
            pin_out_o[i] <= gpio_out_i[i];
            pin_oe_o[i]  <= gpio_oe_i[i];
            if (enabled && routed(route_clk_q) && route_pin(route_clk_q) == i) begin
               pin_out_o[i] <= 1'b0;
               pin_oe_o[i]  <= scl_low;
            end
            if (enabled && routed(route_dat_q) && route_pin(route_dat_q) == i) begin
               pin_out_o[i] <= 1'b0;
               pin_oe_o[i]  <= sda_low;
            end
         end
      end
   end

   // Register writes and event flags; hardware set wins over a clearing read
   always @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= `TWM_ZERO32; links_q <= `TWM_ZERO32; on_q <= 4'h0;
         route_clk_q <= 32'hFFFFFFFF; route_dat_q <= 32'hFFFFFFFF;
         rate_q <= `TWM_RATE_RESET; rx_ptr_q <= `TWM_ZERO32; tx_ptr_q <= `TWM_ZERO32;
         rx_lim_q <= `TWM_ZERO32; tx_lim_q <= `TWM_ZERO32;
         rx_list_q <= `TWM_ZERO32; tx_list_q <= `TWM_ZERO32;
         rx_moved_q <= `TWM_ZERO32; tx_moved_q <= `TWM_ZERO32;
         target_q <= `TWM_ZERO32; cause_q <= 3'h0; ev_q <= 7'h00; tx_side <= 1'b0;
      end else begin
         if (e_rxb) tx_side <= 1'b0;
         if (e_txb) tx_side <= 1'b1;
         if (e_byte && !tx_side) rx_moved_q <= {24'h000000, count};
         if (e_byte && tx_side)  tx_moved_q <= {24'h000000, count};
         if (e_rxb) rx_moved_q <= `TWM_ZERO32;
         if (e_txb) tx_moved_q <= `TWM_ZERO32;
         if (sel_rd) begin
            if (hit(`TWM_OFS_HALTED))   ev_q[0] <= 1'b0;
            if (hit(`TWM_OFS_FAULT))    ev_q[1] <= 1'b0;
            if (hit(`TWM_OFS_PAUSED))   ev_q[2] <= 1'b0;
            if (hit(`TWM_OFS_RX_BEGUN)) ev_q[3] <= 1'b0;
            if (hit(`TWM_OFS_TX_BEGUN)) ev_q[4] <= 1'b0;
            if (hit(`TWM_OFS_FIN_RX))   ev_q[5] <= 1'b0;
            if (hit(`TWM_OFS_FIN_TX))   ev_q[6] <= 1'b0;
         end
         if (sel_wr) begin
            case (wb_adr_i)
               `TWM_OFS_HALTED:    ev_q[0] <= wb_dat_i[0];
               `TWM_OFS_FAULT:     ev_q[1] <= wb_dat_i[0];
               `TWM_OFS_PAUSED:    ev_q[2] <= wb_dat_i[0];
               `TWM_OFS_RX_BEGUN:  ev_q[3] <= wb_dat_i[0];
               `TWM_OFS_TX_BEGUN:  ev_q[4] <= wb_dat_i[0];
               `TWM_OFS_FIN_RX:    ev_q[5] <= wb_dat_i[0];
               `TWM_OFS_FIN_TX:    ev_q[6] <= wb_dat_i[0];
               `TWM_OFS_LINKS:     links_q <= wb_dat_i;
               `TWM_OFS_IRQ_MASK:  mask_q <= wb_dat_i;
               `TWM_OFS_IRQ_SET:   mask_q <= mask_q | wb_dat_i;
               `TWM_OFS_IRQ_CLR:   mask_q <= mask_q & ~wb_dat_i;
               `TWM_OFS_FAULT_CAUSE: cause_q <= cause_q & ~wb_dat_i[2:0];
               `TWM_OFS_ON:        on_q <= wb_dat_i[3:0];
               // Routes ignored while enabled, so a live bus never jumps pins
               `TWM_OFS_CLK_ROUTE: if (!enabled) route_clk_q <= wb_dat_i;
               `TWM_OFS_DAT_ROUTE: if (!enabled) route_dat_q <= wb_dat_i;
               `TWM_OFS_RATE:      rate_q <= wb_dat_i;
               `TWM_OFS_RX_PTR:    rx_ptr_q <= wb_dat_i;
               `TWM_OFS_RX_LIMIT:  rx_lim_q <= {24'h000000, wb_dat_i[7:0]};
               `TWM_OFS_RX_LIST:   rx_list_q <= {29'h00000000, wb_dat_i[2:0]};
               `TWM_OFS_TX_PTR:    tx_ptr_q <= wb_dat_i;
               `TWM_OFS_TX_LIMIT:  tx_lim_q <= {24'h000000, wb_dat_i[7:0]};
               `TWM_OFS_TX_LIST:   tx_list_q <= {29'h00000000, wb_dat_i[2:0]};
               `TWM_OFS_TARGET:    target_q <= {25'h0000000, wb_dat_i[6:0]};
               default: ;
            endcase
         end
         if (e_halt)   ev_q[0] <= 1'b1;
         if (e_fault)  ev_q[1] <= 1'b1;
         if (e_fault)  cause_q[2] <= 1'b1;
         if (e_paused) ev_q[2] <= 1'b1;
         if (e_rxb)    ev_q[3] <= 1'b1;
         if (e_txb)    ev_q[4] <= 1'b1;
         if (e_frx)    ev_q[5] <= 1'b1;
         if (e_ftx)    ev_q[6] <= 1'b1;
      end
   end

   assign irq_o = (ev_q[0] && mask_q[`TWM_EV_HALTED])   || (ev_q[1] && mask_q[`TWM_EV_FAULT])
               || (ev_q[2] && mask_q[`TWM_EV_PAUSED])   || (ev_q[3] && mask_q[`TWM_EV_RX_BEGUN])
               || (ev_q[4] && mask_q[`TWM_EV_TX_BEGUN]) || (ev_q[5] && mask_q[`TWM_EV_FIN_RX])
               || (ev_q[6] && mask_q[`TWM_EV_FIN_TX]);

   always @* begin
      case (wb_adr_i)
         `TWM_OFS_HALTED:      rd_d = {31'h00000000, ev_q[0]};
         `TWM_OFS_FAULT:       rd_d = {31'h00000000, ev_q[1]};
         `TWM_OFS_PAUSED:      rd_d = {31'h00000000, ev_q[2]};
         `TWM_OFS_RX_BEGUN:    rd_d = {31'h00000000, ev_q[3]};
         `TWM_OFS_TX_BEGUN:    rd_d = {31'h00000000, ev_q[4]};
         `TWM_OFS_FIN_RX:      rd_d = {31'h00000000, ev_q[5]};
         `TWM_OFS_FIN_TX:      rd_d = {31'h00000000, ev_q[6]};
         `TWM_OFS_LINKS:       rd_d = links_q;
         `TWM_OFS_IRQ_MASK, `TWM_OFS_IRQ_SET, `TWM_OFS_IRQ_CLR: rd_d = mask_q;
         `TWM_OFS_FAULT_CAUSE: rd_d = {29'h00000000, cause_q};
         `TWM_OFS_ON:          rd_d = {28'h0000000, on_q};
         `TWM_OFS_CLK_ROUTE:   rd_d = route_clk_q;
         `TWM_OFS_DAT_ROUTE:   rd_d = route_dat_q;
         `TWM_OFS_RATE:        rd_d = rate_q;
         `TWM_OFS_RX_PTR:      rd_d = rx_ptr_q;
         `TWM_OFS_RX_LIMIT:    rd_d = rx_lim_q;
         `TWM_OFS_RX_MOVED:    rd_d = rx_moved_q;
         `TWM_OFS_RX_LIST:     rd_d = rx_list_q;
         `TWM_OFS_TX_PTR:      rd_d = tx_ptr_q;
         `TWM_OFS_TX_LIMIT:    rd_d = tx_lim_q;
         `TWM_OFS_TX_MOVED:    rd_d = tx_moved_q;
         `TWM_OFS_TX_LIST:     rd_d = tx_list_q;
         `TWM_OFS_TARGET:      rd_d = target_q;
         default:              rd_d = `TWM_ZERO32;
      endcase
   end

   // One-cycle answer; unmapped and task offsets read zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0; wb_dat_o <= `TWM_ZERO32;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= sel_rd ? rd_d : `TWM_ZERO32;
      end
   end
endmodule
`default_nettype wire

// *** common/twm_consts.vh ***
// Purpose: Offsets, field positions, reset values and timing counts of the two-wire master.
// Assumes: 32-bit Wishbone data, byte addresses, one register per aligned word.
// Notes:   Definitions only.
`ifndef TWM_CONSTS_VH
`define TWM_CONSTS_VH

`define TWM_ADDR_W          12
`define TWM_OFS_RX_GO       12'h000
`define TWM_OFS_TX_GO       12'h008
`define TWM_OFS_HALT        12'h014
`define TWM_OFS_PAUSE       12'h01C
`define TWM_OFS_CONT        12'h020
`define TWM_OFS_HALTED      12'h104
`define TWM_OFS_FAULT       12'h124
`define TWM_OFS_PAUSED      12'h148
`define TWM_OFS_RX_BEGUN    12'h14C
`define TWM_OFS_TX_BEGUN    12'h150
`define TWM_OFS_FIN_RX      12'h15C
`define TWM_OFS_FIN_TX      12'h160
`define TWM_OFS_LINKS       12'h200
`define TWM_OFS_IRQ_MASK    12'h300
`define TWM_OFS_IRQ_SET     12'h304
`define TWM_OFS_IRQ_CLR     12'h308
`define TWM_OFS_FAULT_CAUSE 12'h4C4
`define TWM_OFS_ON          12'h500
`define TWM_OFS_CLK_ROUTE   12'h508
`define TWM_OFS_DAT_ROUTE   12'h50C
`define TWM_OFS_RATE        12'h524
`define TWM_OFS_RX_PTR      12'h534
`define TWM_OFS_RX_LIMIT    12'h538
`define TWM_OFS_RX_MOVED    12'h53C
`define TWM_OFS_RX_LIST     12'h540
`define TWM_OFS_TX_PTR      12'h544
`define TWM_OFS_TX_LIMIT    12'h548
`define TWM_OFS_TX_MOVED    12'h54C
`define TWM_OFS_TX_LIST     12'h550
`define TWM_OFS_TARGET      12'h588

// Event bit positions in the interrupt mask
`define TWM_EV_HALTED       1
`define TWM_EV_FAULT        9
`define TWM_EV_PAUSED       18
`define TWM_EV_RX_BEGUN     19
`define TWM_EV_TX_BEGUN     20
`define TWM_EV_FIN_RX       23
`define TWM_EV_FIN_TX       24

// Event-to-task link bits
`define TWM_LK_FTX_RX       7
`define TWM_LK_FTX_PAUSE    8
`define TWM_LK_FTX_HALT     9
`define TWM_LK_FRX_TX       10
`define TWM_LK_FRX_HALT     12

`define TWM_ON_VALUE        4'h6
`define TWM_ROUTE_OFF_BIT   31
`define TWM_RATE_RESET      32'h00000000
`define TWM_ZERO32          32'h00000000

// Bit time: 2500 ns quarter phase at 100 kbit/s, 100 ns clock
`define TWM_HALF_BIT_NS     2500
`define TWM_CLK_NS          100
`define TWM_HALF_BIT_CYC    (`TWM_HALF_BIT_NS / `TWM_CLK_NS)

`endif

// *** design/twm_bus_engine.v ***
// Purpose: Two-wire bit engine: start, address, bytes with acknowledge, suspend, stop.
// Assumes: Pins already synchronised; open-drain lines driven low only.
// Notes:   One bit per four quarter phases; slave clock stretching honoured.
`default_nettype none
`include "twm_consts.vh"

module twm_bus_engine (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        go_rx_i,
   input  wire        go_tx_i,
   input  wire        halt_i,
   input  wire        pause_i,
   input  wire        cont_i,
   input  wire [6:0]  target_i,
   input  wire [7:0]  rx_limit_i,
   input  wire [7:0]  tx_limit_i,
   input  wire [7:0]  tx_byte_i,
   input  wire        scl_in_i,
   input  wire        sda_in_i,
   output reg         scl_low_o,
   output reg         sda_low_o,
   output reg         ev_halted_o,
   output reg         ev_fault_o,
   output reg         ev_paused_o,
   output reg         ev_rx_begun_o,
   output reg         ev_tx_begun_o,
   output reg         ev_fin_rx_o,
   output reg         ev_fin_tx_o,
   output reg         byte_done_o,
   output reg  [7:0]  rx_byte_o,
   output reg  [7:0]  count_o,
   output wire        busy_o,
   output wire        paused_o
);
   localparam [2:0] S_IDLE = 3'h0, S_START = 3'h1, S_BITS = 3'h2, S_ACK = 3'h3,
                    S_WAIT = 3'h4, S_PAUSE = 3'h5, S_STOP = 3'h6;
   localparam [31:0] HALF_W = `TWM_HALF_BIT_CYC;
   localparam [7:0]  HALF   = HALF_W[7:0];

   reg [2:0] st_q;
   reg [7:0] tmr_q;
   reg [1:0] ph_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg       rd_q, addr_q, halt_pend_q, pause_pend_q;
   wire      tick = (tmr_q == 8'h00);
   wire      last_rx = rd_q && (count_o + 8'h01 >= rx_limit_i);

   assign busy_o   = (st_q != S_IDLE);
   assign paused_o = (st_q == S_PAUSE);

   always @(posedge clk_i) begin
      ev_halted_o <= 1'b0; ev_fault_o <= 1'b0; ev_paused_o <= 1'b0;
      ev_rx_begun_o <= 1'b0; ev_tx_begun_o <= 1'b0;
      ev_fin_rx_o <= 1'b0; ev_fin_tx_o <= 1'b0; byte_done_o <= 1'b0;
      if (rst_i) begin
         st_q <= S_IDLE; tmr_q <= 8'h00; ph_q <= 2'h0; bit_q <= 4'h0;
         sh_q <= 8'h00; rd_q <= 1'b0; addr_q <= 1'b0;
         halt_pend_q <= 1'b0; pause_pend_q <= 1'b0;
         scl_low_o <= 1'b0; sda_low_o <= 1'b0; rx_byte_o <= 8'h00; count_o <= 8'h00;
      end else begin
         tmr_q <= tick ? HALF : tmr_q - 8'h01;
         if (halt_i && st_q != S_PAUSE && st_q != S_IDLE) halt_pend_q <= 1'b1;
         if (pause_i && st_q != S_IDLE) pause_pend_q <= 1'b1;
         case (st_q)
            S_IDLE: begin
               halt_pend_q <= 1'b0; pause_pend_q <= 1'b0;
               if (go_rx_i || go_tx_i) begin
                  rd_q <= go_rx_i; addr_q <= 1'b1; count_o <= 8'h00;
                  sh_q <= {target_i, go_rx_i};
                  ev_rx_begun_o <= go_rx_i;
                  ev_tx_begun_o <= go_tx_i;
                  st_q <= S_START; tmr_q <= HALF;
               end
            end
            S_START: if (tick) begin
               sda_low_o <= 1'b1; st_q <= S_BITS; bit_q <= 4'h0; ph_q <= 2'h0;
            end
            S_BITS, S_ACK: if (tick && !(ph_q == 2'h3 && !scl_in_i)) begin
               ph_q <= ph_q + 2'h1;
               case (ph_q)
                  2'h0: begin
                     scl_low_o <= 1'b1;
                  end
                  2'h1: begin
                     if (st_q == S_BITS)
                        sda_low_o <= (rd_q && !addr_q) ? 1'b0 : !sh_q[7];
                     else
                        sda_low_o <= rd_q && !addr_q && !last_rx;
                  end
                  2'h2: scl_low_o <= 1'b0;
                  default: begin
                     if (st_q == S_BITS) begin
                        sh_q <= {sh_q[6:0], sda_in_i};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7) st_q <= S_ACK;
                     end else begin
                        if ((addr_q || !rd_q) && sda_in_i) ev_fault_o <= 1'b1;
                        if (!addr_q) begin
                           count_o <= count_o + 8'h01;
                           byte_done_o <= 1'b1;
                           if (rd_q) rx_byte_o <= sh_q;
                        end
                        addr_q <= 1'b0;
                        st_q <= S_WAIT;
                     end
                  end
               endcase
            end
            S_WAIT: begin
               // Next byte boundary: stop, suspend, or carry on
               scl_low_o <= 1'b1;
               if (halt_pend_q || (!rd_q && count_o >= tx_limit_i && !addr_q)
                   || (rd_q && count_o >= rx_limit_i)) begin
                  st_q <= S_STOP; sda_low_o <= 1'b1; tmr_q <= HALF;
               end else if (pause_pend_q) begin
                  st_q <= S_PAUSE; pause_pend_q <= 1'b0;
                  ev_paused_o <= 1'b1;
               end else begin
                  ev_fin_rx_o <= last_rx;
                  ev_fin_tx_o <= !rd_q && (count_o + 8'h01 == tx_limit_i);
                  sh_q <= rd_q ? 8'h00 : tx_byte_i;
                  st_q <= S_BITS; bit_q <= 4'h0; ph_q <= 2'h1; tmr_q <= HALF;
               end
            end
            S_PAUSE: if (cont_i) st_q <= S_WAIT;                // Clock held low
            S_STOP: if (tick) begin
               if (scl_low_o) scl_low_o <= 1'b0;
               // Stop edge waits out a stretched clock
               else if (scl_in_i) begin
                  sda_low_o <= 1'b0; st_q <= S_IDLE;
                  ev_halted_o <= 1'b1;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** dv/twm_top_sva.sv ***
// Purpose: Bus, interrupt and pin hand-back checks on the two-wire master.
// Assumes: Mask and enable state tracked from the bus writes seen here.
// Notes:   Bound to every twm_top instance.
`default_nettype none
`include "twm_consts.vh"
module twm_top_sva (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq_o,
   input wire logic [7:0]  gpio_out_i,
   input wire logic [7:0]  gpio_oe_i,
   input wire logic [7:0]  pin_out_o,
   input wire logic [7:0]  pin_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] EVM = 32'h019C0202;
   logic [31:0] mask_q;
   logic        on_q;
   wire logic   wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   always @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= 32'h00000000;
         on_q <= 1'b0;
      end else if (wr) begin
         case (wb_adr_i)
            `TWM_OFS_IRQ_MASK: mask_q <= wb_dat_i & EVM;
            `TWM_OFS_IRQ_SET:  mask_q <= mask_q | (wb_dat_i & EVM);
            `TWM_OFS_IRQ_CLR:  mask_q <= mask_q & ~wb_dat_i;
            `TWM_OFS_ON:       on_q <= (wb_dat_i[3:0] == `TWM_ON_VALUE);
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd_ack;
      wb_ack_o && !wb_we_i;
   endsequence
   a_ack_next_cycle: assert property (s_req |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_task_reads_zero: assert property (s_rd_ack ##0 ($past(wb_adr_i) inside {`TWM_OFS_RX_GO,
      `TWM_OFS_TX_GO, `TWM_OFS_HALT, `TWM_OFS_PAUSE, `TWM_OFS_CONT}) |-> wb_dat_o == 0)
      else $error("write-only task register read nonzero");
   a_unmapped_zero: assert property (s_rd_ack ##0 ($past(wb_adr_i) == 12'hFFC)
      |-> wb_dat_o == 0)
      else $error("unmapped read nonzero");
   a_mask_read_back: assert property (s_rd_ack ##0 ($past(wb_adr_i) == `TWM_OFS_IRQ_MASK)
      |-> (wb_dat_o & EVM) == mask_q)
      else $error("mask read differs from written value");
   a_irq_masked_off: assert property (mask_q == 0 |-> !irq_o)
      else $error("interrupt with all events masked");
   a_gpio_hand_back: assert property (!on_q && !$past(on_q) && !$past(rst_i)
      |-> pin_out_o == $past(gpio_out_i) && pin_oe_o == $past(gpio_oe_i))
      else $error("disabled pins do not follow general-purpose drive");
endmodule
bind twm_top twm_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
   .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
`default_nettype wire

// *** dv/twm_slave_model.sv ***
// Purpose: Two-wire slave that acknowledges its address and write bytes, serves a read byte.
// Assumes: Pulled-up lines; release means the pull-up wins.
// Notes:   Optional clock stretching after each falling clock edge.
`default_nettype none
module twm_slave_model #(
   parameter logic [6:0] ADDR    = 7'h2A,
   parameter logic [7:0] RD_BYTE = 8'hC3
) (
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic slow_i,
   output var  logic scl_low_o,
   output var  logic sda_low_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int         n = 0;
   logic [7:0] sh = 8'h00;
   logic       rd = 0, adr_ph = 0, hit = 0;
   initial scl_low_o = 0;
   initial sda_low_o = 0;
   always @(negedge sda_i) if (scl_i) begin
      n = 0;
      adr_ph = 1;
   end
   always @(posedge sda_i) if (scl_i) hit = 0;
   always @(posedge scl_i) begin
      sh = {sh[6:0], sda_i};
      if (n == 7 && adr_ph) begin
         rd = sda_i;
         hit = (sh[7:1] == ADDR);
      end
      n = (n == 8) ? 0 : n + 1;
      if (n == 0) adr_ph = 0;
   end
   always @(negedge scl_i) begin
      if (n == 8) sda_low_o <= hit && (adr_ph || !rd);
      else sda_low_o <= hit && rd && !adr_ph && !RD_BYTE[7-n];
      if (slow_i) begin
         scl_low_o <= 1;
         #8000 scl_low_o <= 0;
      end
   end
endmodule
`default_nettype wire

// *** dv/two_wire_master_pins_and_regs_bench.sv ***
// Purpose: Register map, pin hand-back and transfer checks of the two-wire master.
// Assumes: Clock on pin 3, data on pin 5, slave at address 2A.
// Notes:   Reads note their expected word in a queue; a monitor compares at ack.
`default_nettype none
`include "twm_consts.vh"
module two_wire_master_pins_and_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, slow = 0;
   logic [11:0] wb_adr_i = 0;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 0, wb_dat_o, v, exp_q[$];
   logic [7:0]  gpio_out_i = 0, gpio_oe_i = 0, tx_byte_i = 8'h5A, pin_out_o, pin_oe_o, rx_byte;
   logic        wb_ack_o, irq_o, rx_valid, scl_lo, sda_lo;
   wire logic [7:0] pin_in = ~(pin_oe_o & ~pin_out_o) & ~{2'b0, sda_lo, 1'b0, scl_lo, 3'b0};
   int          n_errors = 0, checks_done = 0, cyc_n = 0;
   logic [11:0] idle_ofs [6] = '{`TWM_OFS_RX_GO, `TWM_OFS_TX_GO, `TWM_OFS_HALT,
                                 `TWM_OFS_PAUSE, `TWM_OFS_CONT, 12'hFFC};
   twm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .pin_in_i(pin_in),
      .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_out_o(pin_out_o),
      .pin_oe_o(pin_oe_o), .tx_byte_i(tx_byte_i), .rx_byte_o(rx_byte),
      .rx_byte_valid_o(rx_valid), .rx_addr_o(), .tx_addr_o());
   twm_slave_model SLV (.scl_i(pin_in[3]), .sda_i(pin_in[5]), .slow_i(slow),
      .scl_low_o(scl_lo), .sda_low_o(sda_lo));
   always #50 clk_i = ~clk_i;
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 60000) begin
         n_errors++;
         tally_and_finish;
      end
      if (wb_ack_o === 1'b1 && !wb_we_i) chk("wb_dat_o", exp_q.pop_front(), wb_dat_o);
      if (rx_valid === 1'b1) chk("rx_byte_o", 8'hC3, rx_byte);
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wr(a, 0, 0);
   endtask
   task automatic wait_irq;
      for (int n = 0; n < 20000 && irq_o !== 1'b1; n++) @(posedge clk_i);
      chk("irq_o", 1, irq_o);
   endtask
   task automatic xfer(input logic [11:0] go, lim_o, mov_o, beg_o, fin_o,
                       input logic [6:0] tgt, input logic [31:0] lim);
      wr(`TWM_OFS_ON, 0);
      wr(`TWM_OFS_CLK_ROUTE, 3);
      wr(`TWM_OFS_DAT_ROUTE, 5);
      wr(`TWM_OFS_TARGET, tgt);
      wr(lim_o, lim);
      wr(`TWM_OFS_ON, 6);
      wr(`TWM_OFS_CLK_ROUTE, 7);
      rd(`TWM_OFS_CLK_ROUTE, 3);
      wr(`TWM_OFS_IRQ_MASK, tgt == 7'h2A ? 32'h2 : 32'h200);
      tx_byte_i <= $urandom;
      wr(go, 1);
      wait_irq;
      if (tgt != 7'h2A) begin
         rd(`TWM_OFS_FAULT, 1);
         wr(`TWM_OFS_IRQ_MASK, 2);
         wr(`TWM_OFS_HALT, 1);
         wait_irq;
      end
      rd(`TWM_OFS_HALTED, 1);
      chk("irq_o", 0, irq_o);
      rd(beg_o, 1);
      if (tgt == 7'h2A) rd(fin_o, 1);
      if (tgt == 7'h2A) rd(mov_o, lim);
   endtask
   initial begin
      v = $urandom(32'h6e3e1b25);
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      foreach (idle_ofs[i]) rd(idle_ofs[i], 0);
      wr(`TWM_OFS_PAUSE, 1);
      rd(`TWM_OFS_PAUSED, 0);
      v = $urandom;
      wr(`TWM_OFS_IRQ_MASK, v);
      rd(`TWM_OFS_IRQ_MASK, v);
      wr(`TWM_OFS_IRQ_CLR, v);
      rd(`TWM_OFS_IRQ_MASK, 0);
      gpio_out_i <= $urandom;
      gpio_oe_i <= $urandom & 8'hD7;
      repeat (2) @(posedge clk_i);
      chk("pin_out_o", gpio_out_i, pin_out_o);
      chk("pin_oe_o", gpio_oe_i, pin_oe_o);
      xfer(`TWM_OFS_TX_GO, `TWM_OFS_TX_LIMIT, `TWM_OFS_TX_MOVED, `TWM_OFS_TX_BEGUN,
           `TWM_OFS_FIN_TX, 7'h2A, 2);
      slow = 1;
      xfer(`TWM_OFS_RX_GO, `TWM_OFS_RX_LIMIT, `TWM_OFS_RX_MOVED, `TWM_OFS_RX_BEGUN,
           `TWM_OFS_FIN_RX, 7'h2A, 1);
      slow = 0;
      xfer(`TWM_OFS_TX_GO, `TWM_OFS_TX_LIMIT, `TWM_OFS_TX_MOVED, `TWM_OFS_TX_BEGUN,
           `TWM_OFS_FIN_TX, 7'h2B, 2);
      tally_and_finish;
   end
endmodule
`default_nettype wire
